/* File: hw/pcc_pkg.sv */
// Purpose: Shared constants and carriers for the print carrier control block
// Assumes: ref_clk at 40 MHz; processor port strobes synchronous to ref_clk
// Notes:   All offsets, counts and the carrier port reset value live here
// Overview of operation
// (R1) Fire enable low when slot, allowed, window true
// (R2) Odd slot is move_right xor counter lsb
// (R3) Fire only odd pulses, seven per cell
// (R4) Window from tachometer; allowed from flags write
// (R5) Controller engages retracted head before printing
// (R6) Head engaged sense readable on request mux
// (R7) Retract due low readable at port 12
// (R8) Two cascaded nibble counters count forms ticks
// (R9) Counters released only when idle or keyboard load
// (R10) Retract delay jumper selectable, default near 1.6s
// (R11) Motor stop timer shares counter, port 14
// (R12) Port 2 write loads eight data bits
// (R13) Bit 1 picks hold, low high current
// (R14) Bit 2 underline pin nine; bit 3 test point
// (R15) Bit 4 picks interposer solenoid
// (R16) Bit 5 requests standby
// (R17) Bits 6-8 right, fast, go
// (R18) Cell is 20 dot pulses, 14 print
// (R19) Normal print while carrier position readout low
// (R20) Controller times port loads against forms flag
// (R21) Two-phase clocks from toggling base clock
// (R22) Printer load presets scan counter 13 or 0
// (R23) Phase one period twice base period
// (R24) Phases alternate and never overlap
package pcc_pkg;

  // Port addresses on the processor port bus
  localparam logic [3:0] PORT_CARRIER     = 4'h2;
  localparam logic [3:0] PORT_FLAGS       = 4'h3;
  localparam logic [3:0] PORT_FORMS_TICK  = 4'h9;
  localparam logic [3:0] PORT_HEAD_ENG    = 4'hb;
  localparam logic [3:0] PORT_RETRACT_DUE = 4'hc;
  localparam logic [3:0] PORT_MOTOR_STOP  = 4'he;

  // Flags port bit that carries print_allowed
  localparam int FLAG_PRINT_ALLOWED = 0;

  // Carrier port field positions (bit 1 of the port is index 0)
  localparam int CP_HOLD      = 0;
  localparam int CP_UNDERLINE = 1;
  localparam int CP_TEST      = 2;
  localparam int CP_INTERPOSE = 3;
  localparam int CP_STANDBY   = 4;
  localparam int CP_RIGHT     = 5;
  localparam int CP_FAST      = 6;
  localparam int CP_GO        = 7;
  localparam logic [7:0] CARRIER_RESET = 8'h00;

  // Scan counter presets per direction
  localparam logic [3:0] SCAN_PRESET_RIGHT = 4'hd;
  localparam logic [3:0] SCAN_PRESET_LEFT  = 4'h0;
  localparam logic [3:0] SCAN_LAST         = 4'hd;

  // Readout wheel framing
  localparam logic [4:0] DOTS_PER_CELL  = 5'h14;
  localparam logic [4:0] DOTS_PRINTABLE = 5'h0e;

  // Forms tick period is 50 ms, so timer counts ticks; 32 ticks near 1.6 s
  localparam logic [7:0] RETRACT_TICKS_DEFAULT = 8'h20;
  localparam logic [7:0] RETRACT_TICKS_MIN     = 8'h0c;
  localparam logic [7:0] RETRACT_TICKS_MAX     = 8'h78;

  // Base clock 3 us at 25 ns per ref_clk period
  localparam int BASE_PERIOD_NS = 3000;
  localparam int REF_PERIOD_NS  = 25;
  localparam int BASE_HALF_CYC  = BASE_PERIOD_NS / REF_PERIOD_NS / 2;

  // Carrier port decoded drives
  typedef struct packed {
    logic hold_solenoid_drive;
    logic high_current_n;
    logic underline_pin;
    logic test_point_bit;
    logic interposer_drive;
    logic standby_request;
    logic move_right;
    logic fast_move;
    logic move_go;
  } pcc_carrier_s;

  typedef enum logic [1:0] {PCC_PH_IDLE, PCC_PH_ONE, PCC_PH_TWO} pcc_phase_e;

endpackage // pcc_pkg

/* File: hw/pcc_sync.sv */
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: Input may change at any time relative to ref_clk
// Notes:   First flop feeds only the second flop
module pcc_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1;
  logic s2;
  logic s3;

  // Shift chain; output follows only when stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s1        <= 1'b0;
      s2        <= 1'b0;
      s3        <= 1'b0;
      level_out <= 1'b0;
    end
    else if (clk_en)
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        level_out <= s3;
      end
    end
  end

endmodule // pcc_sync

/* File: hw/pcc_top.sv */
// Purpose: Print carrier control glue: fire gating, carrier port, timers,
//          request mux and two-phase clock generation
// Assumes: Processor port strobes are synchronous to ref_clk
// Notes:   Pin and mechanical inputs pass three-flop synchronisers
module pcc_top (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic [3:0]        port_addr,
  input  wire logic [7:0]        proc_data_bits,
  input  wire logic              port_write,
  input  wire logic              printer_load,
  input  wire logic [1:0]        retract_jumper,
  input  wire logic              motor_timer_fitted,
  input  wire logic              dot_position_pulse,
  input  wire logic              carrier_position,
  input  wire logic              fire_window,
  input  wire logic              forms_tick,
  input  wire logic              head_engaged_sense,
  input  wire logic              unit_idle,
  input  wire logic              keyboard_load_init,
  input  wire logic              base_clk,
  output logic                   request_mux,
  output logic                   fire_enable_n,
  output logic                   odd_slot,
  output logic [3:0]             scan_count,
  output logic                   carrier_port_load_n,
  output pcc_pkg::pcc_carrier_s  carrier_out,
  output logic                   head_retract_due_n,
  output logic                   motor_stop_due,
  output logic                   phase_one_n,
  output logic                   phase_two_n
);

  logic       dot_s;
  logic       cpos_s;
  logic       window_s;
  logic       tick_s;
  logic       head_s;
  logic       base_s;
  logic       dot_d;
  logic       tick_d;
  logic       base_d;
  logic       cpos_d;
  logic [7:0] carrier_port;
  logic       print_allowed;
  logic       move_right;
  logic       counter_lsb;
  logic [4:0] cell_dot;
  logic       printing_cell;
  logic [3:0] timer_lo;
  logic [3:0] timer_hi;
  logic       counter_clear_n;
  logic [7:0] retract_limit;
  logic       toggle_ff;
  logic       port_wr_carrier;
  logic       port_wr_flags;
  logic       next_request;
  logic       next_fire_n;

  // Timer value as one byte
  function automatic logic [7:0] timer_value(input logic [3:0] hi, input logic [3:0] lo);
    timer_value = {hi, lo};
  endfunction

  // Synchronise every mechanical or foreign-clock input
  pcc_sync u_sync_dot (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (dot_position_pulse),
    .level_out(dot_s)
  );
  pcc_sync u_sync_cpos (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (carrier_position),
    .level_out(cpos_s)
  );
  pcc_sync u_sync_win (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (fire_window),
    .level_out(window_s)
  );
  pcc_sync u_sync_tick (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (forms_tick),
    .level_out(tick_s)
  );
  pcc_sync u_sync_head (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (head_engaged_sense),
    .level_out(head_s)
  );
  pcc_sync u_sync_base (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (base_clk),
    .level_out(base_s)
  );

  // Port write decode
  always_comb
  begin
    port_wr_carrier = 1'b0;
    port_wr_flags   = 1'b0;
    if (port_write && port_addr == pcc_pkg::PORT_CARRIER)
    begin
      port_wr_carrier = 1'b1; // R12
    end
    else if (port_write && port_addr == pcc_pkg::PORT_FLAGS)
    begin
      port_wr_flags = 1'b1;
    end
  end

  // Edge history of synchronised levels
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dot_d  <= 1'b0;
      tick_d <= 1'b0;
      base_d <= 1'b0;
      cpos_d <= 1'b0;
    end
    else if (clk_en)
    begin
      dot_d  <= dot_s;
      tick_d <= tick_s;
      base_d <= base_s;
      cpos_d <= cpos_s;
    end
  end

  // Carrier port: eight bits taken whole on a port 2 write
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      carrier_port        <= pcc_pkg::CARRIER_RESET;
      carrier_port_load_n <= 1'b1;
    end
    else if (clk_en)
    begin
      carrier_port_load_n <= ~port_wr_carrier; // R12
      if (port_wr_carrier)
      begin
        carrier_port <= proc_data_bits; // R12
      end
    end
  end

  // Carrier drives registered from the port bits
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      carrier_out <= '0;
      carrier_out.high_current_n <= 1'b1;
    end
    else if (clk_en)
    begin
      carrier_out.hold_solenoid_drive <= carrier_port[pcc_pkg::CP_HOLD]; // R13
      carrier_out.high_current_n      <= ~carrier_port[pcc_pkg::CP_HOLD]; // R13
      carrier_out.underline_pin       <= carrier_port[pcc_pkg::CP_UNDERLINE]; // R14
      carrier_out.test_point_bit      <= carrier_port[pcc_pkg::CP_TEST]; // R14
      carrier_out.interposer_drive    <= carrier_port[pcc_pkg::CP_INTERPOSE]; // R15
      carrier_out.standby_request     <= carrier_port[pcc_pkg::CP_STANDBY]; // R16
      carrier_out.move_right          <= carrier_port[pcc_pkg::CP_RIGHT]; // R17
      carrier_out.fast_move           <= carrier_port[pcc_pkg::CP_FAST]; // R17
      carrier_out.move_go             <= carrier_port[pcc_pkg::CP_GO]; // R17
    end
  end

  assign move_right = carrier_port[pcc_pkg::CP_RIGHT];

  // Flags port: print allowed
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      print_allowed <= 1'b0;
    end
    else if (clk_en && port_wr_flags)
    begin
      print_allowed <= proc_data_bits[pcc_pkg::FLAG_PRINT_ALLOWED]; // R4
    end
  end

  // Scan up/down counter: preset on printer load, steps on each dot pulse in the print area until it reaches 0 or 13
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scan_count <= pcc_pkg::SCAN_PRESET_LEFT;
    end
    else if (clk_en)
    begin
      if (printer_load)
      begin
        // Direction picks the preset so pattern addresses run the right way
        scan_count <= move_right ? pcc_pkg::SCAN_PRESET_RIGHT
                                 : pcc_pkg::SCAN_PRESET_LEFT; // R22
      end
      else if (dot_s && !dot_d && printing_cell)
      begin
        if (move_right)
        begin
          scan_count <= (scan_count == 4'h0) ? 4'h0 : scan_count - 4'h1;
        end
        else
        begin
          scan_count <= (scan_count == pcc_pkg::SCAN_LAST) ? scan_count
                                                           : scan_count + 4'h1;
        end
      end
    end
  end

  assign counter_lsb = scan_count[0];

  // Cell framing: carrier position high marks the gap; count dot pulses up to 20
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cell_dot <= 5'h00;
    end
    else if (clk_en)
    begin
      if (cpos_s && !cpos_d)
      begin
        cell_dot <= 5'h00; // R18
      end
      else if (dot_s && !dot_d && cell_dot != pcc_pkg::DOTS_PER_CELL)
      begin
        cell_dot <= cell_dot + 5'h01; // R18
      end
    end
  end

  // Print area is the first 14 pulses while the readout is low
  assign printing_cell = !cpos_s && (cell_dot < pcc_pkg::DOTS_PRINTABLE); // R19

  // Fire gating: odd slot, print allowed and fire window all true
  always_comb
  begin
    next_fire_n = 1'b1;
    if ((move_right ^ counter_lsb) && print_allowed && window_s) // R2 R3
    begin
      next_fire_n = 1'b0; // R1
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      odd_slot      <= 1'b0;
      fire_enable_n <= 1'b1;
    end
    else if (clk_en)
    begin
      odd_slot      <= move_right ^ counter_lsb; // R2
      fire_enable_n <= next_fire_n; // R1 R4
    end
  end

  // Retract timer clear: held until idle or keyboard load says no printing
  assign counter_clear_n = unit_idle | keyboard_load_init; // R9

  // Jumper selection of the retract delay
  always_comb
  begin
    case (retract_jumper)
      2'h0:    retract_limit = pcc_pkg::RETRACT_TICKS_MIN;
      2'h2:    retract_limit = pcc_pkg::RETRACT_TICKS_MAX;
      default: retract_limit = pcc_pkg::RETRACT_TICKS_DEFAULT; // R10
    endcase
  end

  // Two cascaded nibble counters stepping on each forms tick rise
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (clk_en && !counter_clear_n))
    begin
      timer_lo <= 4'h0;
      timer_hi <= 4'h0;
    end
    else if (clk_en && tick_s && !tick_d)
    begin
      // Saturate so the due level stays until cleared
      if (timer_value(timer_hi, timer_lo) != retract_limit)
      begin
        timer_lo <= timer_lo + 4'h1; // R8
        if (timer_lo == 4'hf)
        begin
          timer_hi <= timer_hi + 4'h1; // R8
        end
      end
    end
  end

  // Timer outputs; motor stop shares the same counters
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      head_retract_due_n <= 1'b1;
      motor_stop_due     <= 1'b0;
    end
    else if (clk_en)
    begin
      head_retract_due_n <= ~(timer_value(timer_hi, timer_lo) == retract_limit); // R8 R10
      motor_stop_due     <= motor_timer_fitted &&
                            timer_value(timer_hi, timer_lo) == retract_limit; // R11
    end
  end

  // Request mux selected by the addressed port on reads
  always_comb
  begin
    next_request = 1'b0;
    if (port_addr == pcc_pkg::PORT_HEAD_ENG)
    begin
      next_request = head_s; // R6
    end
    else if (port_addr == pcc_pkg::PORT_RETRACT_DUE)
    begin
      next_request = head_retract_due_n; // R7
    end
    else if (port_addr == pcc_pkg::PORT_MOTOR_STOP)
    begin
      next_request = motor_stop_due; // R11
    end
    else if (port_addr == pcc_pkg::PORT_FORMS_TICK)
    begin
      next_request = tick_s; // R20
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      request_mux <= 1'b0;
    end
    else if (clk_en)
    begin
      request_mux <= next_request;
    end
  end

  // Toggle flips as each base pulse ends, so it holds steady while base is high
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      toggle_ff <= 1'b0;
    end
    else if (clk_en && base_d && !base_s)
    begin
      toggle_ff <= ~toggle_ff; // R21 R23
    end
  end

  // Phases gated with base high; the toggle picks which, so never both
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      phase_one_n <= 1'b1;
      phase_two_n <= 1'b1;
    end
    else if (clk_en)
    begin
      phase_one_n <= ~(base_s && toggle_ff); // R21 R24
      phase_two_n <= ~(base_s && !toggle_ff); // R21 R24
    end
  end

endmodule // pcc_top

/* File: tb/pcc_top_asserts.sv */
// Purpose: Port checks for the print carrier control block
// Assumes: One ref_clk domain; clk_en held high by the bench
// Notes:   Bound to pcc_top from the bench top file
module pcc_top_asserts (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire logic [3:0]            port_addr,
  input wire logic [7:0]            proc_data_bits,
  input wire logic                  port_write,
  input wire logic                  printer_load,
  input wire logic                  unit_idle,
  input wire logic                  keyboard_load_init,
  input wire logic                  request_mux,
  input wire logic                  fire_enable_n,
  input wire logic [3:0]            scan_count,
  input wire logic                  carrier_port_load_n,
  input wire pcc_pkg::pcc_carrier_s carrier_out,
  input wire logic                  head_retract_due_n,
  input wire logic                  motor_stop_due,
  input wire logic                  phase_one_n,
  input wire logic                  phase_two_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Drives expected from one port byte; bit 1 also gives the inverted current enable
  function automatic pcc_pkg::pcc_carrier_s exp_c(input logic [7:0] d);
    return {d[0], ~d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
  endfunction

  // Cycles since phase one went active; trusted only after a first such edge
  logic       ph1_q;
  logic [8:0] gap;
  logic       gap_ok;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ph1_q  <= 1'b1;
      gap    <= 9'h000;
      gap_ok <= 1'b0;
    end
    else
    begin
      ph1_q  <= phase_one_n;
      gap    <= (ph1_q && !phase_one_n) ? 9'h000 : gap + 9'h001;
      gap_ok <= gap_ok || (ph1_q && !phase_one_n);
    end
  end

  property p_load_pulse;
    port_write && port_addr == pcc_pkg::PORT_CARRIER |=> !carrier_port_load_n ##1
      (carrier_port_load_n || $past(port_write && port_addr == pcc_pkg::PORT_CARRIER));
  endproperty
  a_load_pulse:
    assert property (p_load_pulse) else $error("carrier load strobe wrong");
  property p_carrier_load;
    port_write && port_addr == pcc_pkg::PORT_CARRIER |->
      ##2 carrier_out == exp_c($past(proc_data_bits, 2));
  endproperty
  a_carrier_load:
    assert property (p_carrier_load) else $error("carrier drives wrong");
  property p_fire_slot;
    !fire_enable_n |-> carrier_out.move_right ^ $past(scan_count[0]);
  endproperty
  a_fire_slot:
    assert property (p_fire_slot) else $error("fire outside odd slot");
  property p_scan_preset;
    printer_load |=> scan_count == (carrier_out.move_right ?
      pcc_pkg::SCAN_PRESET_RIGHT : pcc_pkg::SCAN_PRESET_LEFT);
  endproperty
  a_scan_preset:
    assert property (p_scan_preset) else $error("scan preset wrong");
  property p_phase_excl;
    phase_one_n || phase_two_n;
  endproperty
  a_phase_excl:
    assert property (p_phase_excl) else $error("phases overlap");
  property p_phase_alt;
    $fell(phase_two_n) && gap_ok |-> gap == 9'h077;
  endproperty
  a_phase_alt:
    assert property (p_phase_alt) else $error("phase two not one base period later");
  property p_phase_period;
    $fell(phase_one_n) && gap_ok |-> gap == 9'h0ef;
  endproperty
  a_phase_period:
    assert property (p_phase_period) else $error("phase one period wrong");
  property p_req_retract;
    port_addr == pcc_pkg::PORT_RETRACT_DUE |=> request_mux == $past(head_retract_due_n);
  endproperty
  a_req_retract:
    assert property (p_req_retract) else $error("retract due not on request line");
  property p_req_motor;
    port_addr == pcc_pkg::PORT_MOTOR_STOP |=> request_mux == $past(motor_stop_due);
  endproperty
  a_req_motor:
    assert property (p_req_motor) else $error("motor stop not on request line");
  property p_retract_clear;
    (!unit_idle && !keyboard_load_init) [*2] |=> head_retract_due_n;
  endproperty
  a_retract_clear:
    assert property (p_retract_clear) else $error("retract due while held clear");
endmodule // pcc_top_asserts

/* File: tb/pcc_cpu_model.sv */
// Purpose: Control processor model: port writes, printer loads, request polls
// Assumes: The block takes port strobes on ref_clk rising edges
// Notes:   Data bus is inverted after each write so stale data never looks valid
module pcc_cpu_model (
  input  wire logic ref_clk,
  input  wire logic request_mux,
  output logic [3:0] port_addr,
  output logic [7:0] proc_data_bits,
  output logic       port_write,
  output logic       printer_load
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    port_addr      = 4'h0;
    proc_data_bits = 8'h00;
    port_write     = 1'b0;
    printer_load   = 1'b0;
  end

  // One write; strobe and data held for exactly the taking edge
  task automatic write_port(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    port_addr      <= a;
    proc_data_bits <= d;
    port_write     <= 1'b1;
    @(posedge ref_clk);
    port_write     <= 1'b0;
    proc_data_bits <= ~d;
  endtask

  // Poll a request input; the answer trails the address by one cycle
  task automatic read_req(input logic [3:0] a, output logic v);
    @(posedge ref_clk);
    port_addr <= a;
    repeat (2) @(posedge ref_clk);
    v = request_mux;
  endtask

  // Printer load presets the scan counter for the current direction
  task automatic load_printer();
    @(posedge ref_clk);
    printer_load <= 1'b1;
    @(posedge ref_clk);
    printer_load <= 1'b0;
  endtask

  // Carrier commands wait for the forms flag; bounded so a dead flag cannot hang
  task automatic wait_forms(output logic ok);
    ok = 1'b0;
    repeat (100)
    begin
      read_req(pcc_pkg::PORT_FORMS_TICK, ok);
      if (ok === 1'b1)
        break;
    end
  endtask
endmodule // pcc_cpu_model

/* File: tb/pcc_top_tb.sv */
// Purpose: Self-checking bench for the print carrier control block
// Assumes: Processor model drives the port bus; pins change at ref_clk edges
// Notes:   clk_en is held high; the freeze path is left unexercised
module pcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  ref_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  base_clk = 1'b0;
  logic [1:0]            retract_jumper = 2'h1;
  logic                  motor_timer_fitted = 1'b0;
  logic                  dot_position_pulse = 1'b0;
  logic                  carrier_position = 1'b0;
  logic                  fire_window = 1'b0;
  logic                  forms_tick = 1'b0;
  logic                  head_engaged_sense = 1'b0;
  logic                  unit_idle = 1'b0;
  logic                  keyboard_load_init = 1'b0;
  logic [2:0]            prev = 3'h7;
  logic [3:0]            port_addr, scan_count;
  logic [7:0]            proc_data_bits;
  logic                  port_write, printer_load, request_mux, fire_enable_n, odd_slot;
  logic                  carrier_port_load_n, head_retract_due_n, motor_stop_due;
  logic                  phase_one_n, phase_two_n;
  pcc_pkg::pcc_carrier_s carrier_out;
  int                    mismatches = 0, comparisons = 0, cycles = 0;
  int                    fires = 0, ph1_falls = 0, ph2_falls = 0;

  pcc_top pcc_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .port_addr(port_addr),
    .proc_data_bits(proc_data_bits), .port_write(port_write), .printer_load(printer_load),
    .retract_jumper(retract_jumper), .motor_timer_fitted(motor_timer_fitted),
    .dot_position_pulse(dot_position_pulse), .carrier_position(carrier_position),
    .fire_window(fire_window), .forms_tick(forms_tick), .base_clk(base_clk),
    .head_engaged_sense(head_engaged_sense), .unit_idle(unit_idle),
    .keyboard_load_init(keyboard_load_init), .request_mux(request_mux),
    .fire_enable_n(fire_enable_n), .odd_slot(odd_slot), .scan_count(scan_count),
    .carrier_port_load_n(carrier_port_load_n), .carrier_out(carrier_out),
    .head_retract_due_n(head_retract_due_n), .motor_stop_due(motor_stop_due),
    .phase_one_n(phase_one_n), .phase_two_n(phase_two_n));

  pcc_cpu_model pcc_cpu_model_i (
    .ref_clk(ref_clk), .request_mux(request_mux), .port_addr(port_addr),
    .proc_data_bits(proc_data_bits), .port_write(port_write), .printer_load(printer_load));

  // Processor clock and an unrelated 3 us base clock
  always #12.5 ref_clk = ~ref_clk;
  always #1500 base_clk = ~base_clk;

  // Cycle limit, plus falling-edge counts of fire enable and both phases
  always @(posedge ref_clk)
  begin
    cycles++;
    prev <= {fire_enable_n, phase_one_n, phase_two_n};
    if (prev[2] && !fire_enable_n)
      fires++;
    if (prev[1] && !phase_one_n)
      ph1_falls++;
    if (prev[0] && !phase_two_n)
      ph2_falls++;
    if (cycles == 40000)
    begin
      mismatches++;
      conclude();
    end
  end

  function automatic logic [8:0] exp_carrier(input logic [7:0] d);
    return {d[0], ~d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
  endfunction

  function automatic int ticks(input int j);
    return (j == 0) ? int'(pcc_pkg::RETRACT_TICKS_MIN) : (j == 2) ?
      int'(pcc_pkg::RETRACT_TICKS_MAX) : int'(pcc_pkg::RETRACT_TICKS_DEFAULT);
  endfunction

  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Pulses last several cycles each way so the pin synchronisers agree
  task automatic tick();
    forms_tick <= 1'b1;
    repeat (8) @(posedge ref_clk);
    forms_tick <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic dot();
    dot_position_pulse <= 1'b1;
    repeat (5) @(posedge ref_clk);
    dot_position_pulse <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic conclude();
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    logic [7:0] d;
    logic       v;
    void'($urandom(61060));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    forms_tick <= 1'b1;
    pcc_cpu_model_i.wait_forms(v);
    check(9'(v), 9'h001, "forms flag");
    forms_tick <= 1'b0;
    // Carrier port: extremes then random bytes; a write elsewhere must not land
    for (int i = 0; i < 10; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      pcc_cpu_model_i.write_port(pcc_pkg::PORT_CARRIER, d);
      repeat (3) @(posedge ref_clk);
      check(carrier_out, exp_carrier(d), "carrier drives");
      pcc_cpu_model_i.write_port(4'h5, ~d);
      repeat (3) @(posedge ref_clk);
      check(carrier_out, exp_carrier(d), "foreign write");
    end
    // Head switch in both states
    for (int i = 1; i >= 0; i--)
    begin
      head_engaged_sense <= i[0];
      repeat (6) @(posedge ref_clk);
      pcc_cpu_model_i.read_req(pcc_pkg::PORT_HEAD_ENG, v);
      check(9'(v), 9'(i[0]), "head sense");
    end
    // Retract timer per jumper code, released by idle or by keyboard load
    for (int j = 0; j < 4; j++)
    begin
      unit_idle          <= 1'b0;
      keyboard_load_init <= 1'b0;
      retract_jumper     <= 2'(j);
      motor_timer_fitted <= j[1];
      repeat (4) @(posedge ref_clk);
      check(9'(head_retract_due_n), 9'h001, "held timer");
      unit_idle          <= !j[0];
      keyboard_load_init <= j[0];
      repeat (ticks(j) - 1) tick();
      check(9'(head_retract_due_n), 9'h001, "early retract");
      tick();
      pcc_cpu_model_i.read_req(pcc_pkg::PORT_RETRACT_DUE, v);
      check(9'(v), 9'h000, "retract due");
      pcc_cpu_model_i.read_req(pcc_pkg::PORT_MOTOR_STOP, v);
      check(9'(v), 9'(j[1]), "motor stop");
    end
    // One cell per direction, print-allowed and fire-window combination
    for (int k = 0; k < 8; k++)
    begin
      pcc_cpu_model_i.write_port(pcc_pkg::PORT_FLAGS, {7'h00, k[1]});
      pcc_cpu_model_i.write_port(pcc_pkg::PORT_CARRIER, {2'h2, k[0], 5'h00});
      fire_window      <= k[2];
      carrier_position <= 1'b1;
      repeat (6) @(posedge ref_clk);
      carrier_position <= 1'b0;
      pcc_cpu_model_i.load_printer();
      repeat (2) @(posedge ref_clk);
      check(9'(scan_count), 9'(k[0] ? pcc_pkg::SCAN_PRESET_RIGHT :
        pcc_pkg::SCAN_PRESET_LEFT), "scan preset");
      check(9'(odd_slot), 9'h000, "odd slot at preset");
      fires = 0;
      repeat (14) dot();
      repeat (8) @(posedge ref_clk);
      check(9'(fires), (k[1] && k[2]) ? 9'h007 : 9'h000, "fires per cell");
      check(9'(odd_slot), 9'h001, "odd slot at cell end");
    end
    // Ten phase-one periods; zeroed off the edge so no fall is half counted
    @(negedge ref_clk);
    ph1_falls = 0;
    ph2_falls = 0;
    repeat (2400) @(posedge ref_clk);
    @(negedge ref_clk);
    check(9'(ph1_falls), 9'h00a, "phase one count");
    check(9'(ph2_falls), 9'h00a, "phase two count");
    conclude();
  end
endmodule // pcc_top_tb

bind pcc_top pcc_top_asserts pcc_top_asserts_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .port_addr(port_addr),
  .proc_data_bits(proc_data_bits), .port_write(port_write), .printer_load(printer_load),
  .unit_idle(unit_idle), .keyboard_load_init(keyboard_load_init),
  .request_mux(request_mux), .fire_enable_n(fire_enable_n), .scan_count(scan_count),
  .carrier_port_load_n(carrier_port_load_n), .carrier_out(carrier_out),
  .head_retract_due_n(head_retract_due_n), .motor_stop_due(motor_stop_due),
  .phase_one_n(phase_one_n), .phase_two_n(phase_two_n));
